// ### test/core_memory_model.sv
// Core memory stand-in that puts the addressed word on the sense amplifier lines.
// Assumes the sequencer's T2 pulse marks the only window in which the word is valid.
`timescale 1ns/1ps
module core_memory_model #(
    parameter int W = 18
) (
    input wire logic i_t2,
    input wire logic [W-1:0] i_word,
    output logic [W-1:0] o_sense
);
    // Outside the read window the lines show the inverse, so a mistimed strobe picks up garbage.
    assign o_sense = i_t2 ? i_word : ~i_word;
endmodule

// ### test/cpu_register_transfer_control_tb.sv
// Self-checking bench: cycle table, pulse order, console examine, I/O skip and reset values.
// Assumes the core memory model beside it and a classic Wishbone master driven from here.
`timescale 1ns/1ps
module cpu_register_transfer_control_tb;
    typedef struct packed {
        logic [6:0] cyc;
        logic [6:0] op;
        logic [12:0] pc;
        logic [17:0] ac;
        logic [17:0] sense;
        logic ma_ok;
        logic [12:0] ma;
        logic [17:0] mb;
        logic inh;
        logic [12:0] pc_after;
    } row_t;
    localparam int NROW = 14;
    // Each execute or plain defer row addresses memory with the buffer left by the row before.
    row_t rows [NROW] = '{
        '{7'h40, 7'h00, 13'h0005, 18'h0, 18'h2ABCD, 1'b1, 13'h0005, 18'h2ABCD, 1'b0, 13'h0006},
        '{7'h10, 7'h08, 13'h0100, 18'h01234, 18'h3FFFF, 1'b1, 13'h0BCD, 18'h01234, 1'b0, 13'h0100},
        '{7'h20, 7'h02, 13'h0100, 18'h0, 18'h0000A, 1'b1, 13'h0010, 18'h0000A, 1'b0, 13'h0100},
        '{7'h20, 7'h00, 13'h0100, 18'h0, 18'h00041, 1'b1, 13'h000A, 18'h00042, 1'b0, 13'h0100},
        '{7'h10, 7'h10, 13'h0100, 18'h0, 18'h3FFFF, 1'b1, 13'h0042, 18'h00000, 1'b0, 13'h0101},
        '{7'h10, 7'h10, 13'h0100, 18'h0, 18'h00005, 1'b1, 13'h0000, 18'h00006, 1'b0, 13'h0100},
        '{7'h01, 7'h00, 13'h0100, 18'h0, 18'h00100, 1'b0, 13'h0000, 18'h00101, 1'b0, 13'h0100},
        '{7'h08, 7'h00, 13'h0123, 18'h0, 18'h2AAAA, 1'b0, 13'h0000, 18'h00123, 1'b1, 13'h0124},
        '{7'h10, 7'h20, 13'h0200, 18'h0, 18'h15555, 1'b1, 13'h0123, 18'h00200, 1'b1, 13'h0201},
        '{7'h10, 7'h04, 13'h0200, 18'h0, 18'h3FFFF, 1'b1, 13'h0200, 18'h00000, 1'b1, 13'h0200},
        '{7'h06, 7'h00, 13'h0200, 18'h0, 18'h3FFFF, 1'b0, 13'h0000, 18'h00000, 1'b1, 13'h0200},
        '{7'h10, 7'h40, 13'h0300, 18'h00001, 18'h0, 1'b1, 13'h0000, 18'h00000, 1'b0, 13'h0301},
        '{7'h10, 7'h01, 13'h0300, 18'h0, 18'h00080, 1'b1, 13'h0000, 18'h00080, 1'b0, 13'h0301},
        '{7'h10, 7'h01, 13'h0300, 18'h0, 18'h00280, 1'b1, 13'h0080, 18'h00280, 1'b0, 13'h0300}
    };
    logic [7:0] adrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
    logic i_ref_clk;
    logic i_reset = 1'b1;
    cpu_xfer_pkg::wb_req_t wb = '0;
    cpu_xfer_pkg::wb_rsp_t o_wb;
    cpu_xfer_pkg::cycle_t cyc = '0;
    cpu_xfer_pkg::op_t op = '0;
    cpu_xfer_pkg::keys_t keys = '0;
    logic io_skip = 1'b0;
    logic trap_flag = 1'b0;
    logic run;
    logic [17:0] mem_word = 18'h00000;
    logic [17:0] sense;
    logic [6:0] timing;
    logic [4:0] kp;
    logic [12:0] ma;
    logic [17:0] mb;
    logic inh;
    logic [31:0] rd;
    int num_errors = 0;
    int check_count = 0;

    cpu_register_transfer_control dut_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_wb(wb),
        .o_wb(o_wb), .i_cycle(cyc), .i_op(op), .i_keys(keys), .i_sense(sense), .i_link(1'b0),
        .i_io_skip(io_skip), .i_trap_flag(trap_flag), .o_timing(timing), .o_key_pulse(kp),
        .o_memory_address(ma), .o_memory_buffer(mb), .o_strobe_inhibit(inh), .o_run(run));
    core_memory_model mem_u (.i_t2(timing[cpu_xfer_pkg::T2]), .i_word(mem_word), .o_sense(sense));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t value seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        wb <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (o_wb.ack !== 1'b1 && n < 20);
        if (o_wb.ack !== 1'b1)
        begin
            num_errors++;
            conclude();
        end
        else
        begin
            rd = o_wb.dat;
            wb <= '0;
        end
    endtask

    task automatic wait_bit(input logic key, input int k);
        int n;
        n = 0;
        do
        begin
            @(negedge i_ref_clk);
            n++;
        end
        while ((key ? kp[k] : timing[k]) !== 1'b1 && n < 200);
        if ((key ? kp[k] : timing[k]) !== 1'b1)
        begin
            num_errors++;
            conclude();
        end
    endtask

    initial
    begin
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        for (int i = 0; i < NROW; i++)
        begin
            wb_xfer(1'b1, cpu_xfer_pkg::ADR_PC, {19'h0, rows[i].pc});
            wb_xfer(1'b1, cpu_xfer_pkg::ADR_AC, {14'h0, rows[i].ac});
            mem_word <= rows[i].sense;
            cyc <= rows[i].cyc;
            op <= rows[i].op;
            // Run drops again before T7, so exactly one memory cycle is made.
            wb_xfer(1'b1, cpu_xfer_pkg::ADR_CTRL, 32'h1);
            wb_xfer(1'b1, cpu_xfer_pkg::ADR_CTRL, 32'h0);
            wait_bit(1'b0, cpu_xfer_pkg::T3);
            @(negedge i_ref_clk);
            if (rows[i].ma_ok)
                check(ma, rows[i].ma);
            check(mb, rows[i].mb);
            check(inh, rows[i].inh);
            wait_bit(1'b0, cpu_xfer_pkg::T7);
            wb_xfer(1'b0, cpu_xfer_pkg::ADR_PC, 32'h0);
            check(rd, rows[i].pc_after);
        end
        $display("test cycle table done");
        cyc <= 7'h40;
        op <= '0;
        wb_xfer(1'b1, cpu_xfer_pkg::ADR_CTRL, 32'h1);
        wait_bit(1'b0, cpu_xfer_pkg::T1);
        check(run, 1'b1);
        for (int k = 1; k < 7; k++)
        begin
            @(negedge i_ref_clk);
            check(timing, 32'h1 << k);
        end
        @(negedge i_ref_clk);
        check(ma, 13'h0000);
        wb_xfer(1'b1, cpu_xfer_pkg::ADR_CTRL, 32'h0);
        $display("test pulse order done");
        repeat (10) @(posedge i_ref_clk);
        cyc <= '0;
        wb_xfer(1'b1, cpu_xfer_pkg::ADR_PC, 32'h0777);
        keys.examine <= 1'b1;
        wait_bit(1'b1, cpu_xfer_pkg::SP1);
        @(negedge i_ref_clk);
        check(ma, 13'h0000);
        wait_bit(1'b1, cpu_xfer_pkg::SP3);
        @(negedge i_ref_clk);
        check(mb, 18'h00777);
        repeat (3) @(posedge i_ref_clk);
        keys.examine <= 1'b0;
        wb_xfer(1'b0, cpu_xfer_pkg::ADR_PC, 32'h0);
        check(rd, 32'h0778);
        io_skip <= 1'b1;
        @(posedge i_ref_clk);
        io_skip <= 1'b0;
        wb_xfer(1'b0, cpu_xfer_pkg::ADR_PC, 32'h0);
        check(rd, 32'h0779);
        // A dropping trap flag arms one extra step at T6 of the next program break.
        trap_flag <= 1'b1;
        @(posedge i_ref_clk);
        trap_flag <= 1'b0;
        wb_xfer(1'b1, cpu_xfer_pkg::ADR_PC, 32'h0400);
        cyc <= 7'h08;
        wb_xfer(1'b1, cpu_xfer_pkg::ADR_CTRL, 32'h1);
        wb_xfer(1'b1, cpu_xfer_pkg::ADR_CTRL, 32'h0);
        wait_bit(1'b0, cpu_xfer_pkg::T7);
        wb_xfer(1'b0, cpu_xfer_pkg::ADR_PC, 32'h0);
        check(rd, 32'h0402);
        cyc <= '0;
        $display("test keys and skip done");
        i_reset <= 1'b1;
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        foreach (adrs[j])
        begin
            wb_xfer(1'b0, adrs[j], 32'h0);
            check(rd, 32'h0);
        end
        check(ma, 13'h0000);
        check(mb, 18'h00000);
        check(run, 1'b0);
        $display("test reset done");
        conclude();
    end
endmodule

// ### verilog/cpu_register_transfer_control.sv
// Command pulse logic that loads, clears and increments the program counter, memory address
// and memory buffer registers, plus the memory cycle and key cycle pulse sequencer.
// Assumes cycle, decoder and break levels come from logic on i_ref_clk; console keys are pins.
// Function
// - Increment program counter at T1 of every fetch cycle.
// - Skip-if-differ execute: increment program counter at T5 when accumulator nonzero.
// - Increment program counter at T5 of subroutine-jump execute or program break.
// - Increment-skip-zero execute: increment program counter at T3 when buffer wraps.
// - Operate skip: increment program counter at T5 when combined skip holds.
// - Trap mode: increment program counter at T6 of break after trap.
// - Increment program counter when identified peripheral flag is set.
// - Increment program counter at SP2 tape read and SP4 examine/deposit.
// - Clear memory address at SP1 of any non-stop key cycle.
// - Clear memory address at T7 of every cycle while running.
// - Copy program counter to memory address at T1 of fetch.
// - Copy buffer bits 5-17 to memory address at T1 defer/execute, non-call.
// - Load memory address with octal 20 at T1 of call defer/execute.
// - Clear buffer at key begin, every T2, and readin execute T7.
// - Sense amplifier ones set buffer bits at T2 of every cycle read whose strobe is not inhibited.
// - Inhibit sense strobe on program break, inbound data break, jump/zero execute.
// - Increment buffer at T3 of defer to auto-index locations 10-17.
// - Increment buffer at T3 of a granted clock break.
// - Increment buffer at T3 of increment-skip-zero execute.
// - Copy accumulator into buffer at T3 of deposit-accumulator execute only.
// - Copy program counter into buffer at SP4 of tape read.
// - Copy program counter into buffer at SP3 of examine/deposit.
// - Copy program counter into buffer at T3 of break or subroutine-jump.
`timescale 1ns/1ps
module cpu_register_transfer_control #(
    parameter int WORD_W = cpu_xfer_pkg::WORD_W,
    parameter int ADDR_W = cpu_xfer_pkg::ADDR_W
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire cpu_xfer_pkg::wb_req_t i_wb,
    output cpu_xfer_pkg::wb_rsp_t o_wb,
    input wire cpu_xfer_pkg::cycle_t i_cycle,
    input wire cpu_xfer_pkg::op_t i_op,
    input wire cpu_xfer_pkg::keys_t i_keys,
    input wire logic [WORD_W-1:0] i_sense,
    input wire logic i_link,
    input wire logic i_io_skip,
    input wire logic i_trap_flag,
    output logic [cpu_xfer_pkg::NUM_T-1:0] o_timing,
    output logic [cpu_xfer_pkg::NUM_SP-1:0] o_key_pulse,
    output logic [ADDR_W-1:0] o_memory_address,
    output logic [WORD_W-1:0] o_memory_buffer,
    output logic o_strobe_inhibit,
    output logic o_run
);
    if (WORD_W != cpu_xfer_pkg::WORD_W || ADDR_W != cpu_xfer_pkg::ADDR_W)
    begin : bad_width
        $error("Word and address widths are fixed by the bit positions of the package");
    end

    typedef struct packed {
        cpu_xfer_pkg::seq_mode_t mode;
        logic [cpu_xfer_pkg::NUM_T-1:0] tp;
        logic [cpu_xfer_pkg::NUM_SP-1:0] kp;
        logic run;
        logic readin;
        logic key_ex_dep;
        logic key_start;
        logic trap_pend;
        logic trap_seen;
        logic inhibit;
        cpu_xfer_pkg::keys_t key_sync1;
        cpu_xfer_pkg::keys_t key_sync2;
        cpu_xfer_pkg::keys_t key_prev;
        logic [ADDR_W-1:0] program_counter;
        logic [ADDR_W-1:0] memory_address_reg;
        logic [WORD_W-1:0] memory_buffer_reg;
        logic [WORD_W-1:0] accumulator_reg;
        cpu_xfer_pkg::wb_rsp_t rsp;
    } state_t;

    state_t s;
    state_t next_s;

    function automatic cpu_xfer_pkg::reg_sel_t reg_decode(input logic [7:0] adr);
        if (adr == cpu_xfer_pkg::ADR_CTRL)
            reg_decode = cpu_xfer_pkg::RS_CTRL;
        else if (adr == cpu_xfer_pkg::ADR_STATUS)
            reg_decode = cpu_xfer_pkg::RS_STATUS;
        else if (adr == cpu_xfer_pkg::ADR_PC)
            reg_decode = cpu_xfer_pkg::RS_PC;
        else if (adr == cpu_xfer_pkg::ADR_MA)
            reg_decode = cpu_xfer_pkg::RS_MA;
        else if (adr == cpu_xfer_pkg::ADR_MB)
            reg_decode = cpu_xfer_pkg::RS_MB;
        else if (adr == cpu_xfer_pkg::ADR_AC)
            reg_decode = cpu_xfer_pkg::RS_AC;
        else
            reg_decode = cpu_xfer_pkg::RS_NONE;
    endfunction

    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        byte_merge = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                byte_merge[b*8 +: 8] = wd[b*8 +: 8];
        end
    endfunction

    // Bit 8 clear ORs the selected conditions; bit 8 set ANDs their inverted forms.
    function automatic logic op_skip(input logic [WORD_W-1:0] mb, input logic [WORD_W-1:0] ac,
                                     input logic link);
        logic any_sel;
        any_sel = mb[cpu_xfer_pkg::MB9] | mb[cpu_xfer_pkg::MB10] | mb[cpu_xfer_pkg::MB11];
        if (!mb[cpu_xfer_pkg::MB8])
            op_skip = (mb[cpu_xfer_pkg::MB9] & link) | (mb[cpu_xfer_pkg::MB10] & (ac == '0))
                      | (mb[cpu_xfer_pkg::MB11] & ac[cpu_xfer_pkg::AC_SIGN]);
        else
            op_skip = any_sel & (~mb[cpu_xfer_pkg::MB9] | ~link)
                      & (~mb[cpu_xfer_pkg::MB10] | (ac != '0))
                      & (~mb[cpu_xfer_pkg::MB11] | ~ac[cpu_xfer_pkg::AC_SIGN]);
    endfunction

    logic bus_req;
    logic bus_wr;
    cpu_xfer_pkg::reg_sel_t sel_reg;
    cpu_xfer_pkg::keys_t rise;
    logic key_go;
    logic pc_inc;
    logic auto_index;
    logic trap_fall;
    logic trap_use;
    logic [31:0] rd;

    always_comb
    begin
        next_s = s;
        bus_req = i_wb.cyc & i_wb.stb;
        // A write lands on the edge where ack is seen high, matching when the master lets go.
        bus_wr = bus_req & i_wb.we & s.rsp.ack;
        sel_reg = reg_decode(i_wb.adr);
        rd = '0;
        if (sel_reg == cpu_xfer_pkg::RS_CTRL)
            rd[cpu_xfer_pkg::CTRL_RUN] = s.run;
        else if (sel_reg == cpu_xfer_pkg::RS_STATUS)
        begin
            rd[cpu_xfer_pkg::ST_RUN] = s.run;
            rd[cpu_xfer_pkg::ST_BUSY] = s.mode != cpu_xfer_pkg::SEQ_IDLE;
            rd[cpu_xfer_pkg::ST_READIN] = s.readin;
            rd[cpu_xfer_pkg::ST_INHIBIT] = s.inhibit;
        end
        else if (sel_reg == cpu_xfer_pkg::RS_PC)
            rd[ADDR_W-1:0] = s.program_counter;
        else if (sel_reg == cpu_xfer_pkg::RS_MA)
            rd[ADDR_W-1:0] = s.memory_address_reg;
        else if (sel_reg == cpu_xfer_pkg::RS_MB)
            rd[WORD_W-1:0] = s.memory_buffer_reg;
        else if (sel_reg == cpu_xfer_pkg::RS_AC)
            rd[WORD_W-1:0] = s.accumulator_reg;
        next_s.rsp.ack = bus_req & ~s.rsp.ack;
        next_s.rsp.dat = rd;
        if (bus_wr && sel_reg == cpu_xfer_pkg::RS_CTRL && i_wb.sel[0])
            next_s.run = i_wb.dat[cpu_xfer_pkg::CTRL_RUN];
        if (bus_wr && sel_reg == cpu_xfer_pkg::RS_PC)
            next_s.program_counter = ADDR_W'(byte_merge(32'(s.program_counter), i_wb.dat,
                                                        i_wb.sel));
        if (bus_wr && sel_reg == cpu_xfer_pkg::RS_AC)
            next_s.accumulator_reg = WORD_W'(byte_merge(32'(s.accumulator_reg), i_wb.dat,
                                                        i_wb.sel));

        // Keys are asynchronous pins; edges are taken only from the second stage onward.
        next_s.key_sync1 = i_keys;
        next_s.key_sync2 = s.key_sync1;
        next_s.key_prev = s.key_sync2;
        rise = s.key_sync2 & ~s.key_prev;
        key_go = ~s.run & (rise.start | rise.examine | rise.deposit | rise.readin);
        if (rise.stop)
        begin
            next_s.run = 1'b0;
            next_s.readin = 1'b0;
        end

        // Sequencer: one pulse slot per clock.
        next_s.tp = '0;
        next_s.kp = '0;
        case (s.mode)
            cpu_xfer_pkg::SEQ_IDLE:
            begin
                if (s.run)
                begin
                    next_s.mode = cpu_xfer_pkg::SEQ_MEM;
                    next_s.tp[cpu_xfer_pkg::T1] = 1'b1;
                end
                else if (key_go)
                begin
                    next_s.mode = cpu_xfer_pkg::SEQ_KEY;
                    next_s.kp[cpu_xfer_pkg::KBGN] = 1'b1;
                    next_s.key_ex_dep = rise.examine | rise.deposit;
                    next_s.key_start = rise.start | rise.readin;
                    next_s.readin = rise.readin;
                end
            end
            cpu_xfer_pkg::SEQ_MEM:
            begin
                if (!s.tp[cpu_xfer_pkg::T7])
                    next_s.tp = {s.tp[cpu_xfer_pkg::NUM_T-2:0], 1'b0};
                else if (s.run)
                    next_s.tp[cpu_xfer_pkg::T1] = 1'b1;
                else
                    next_s.mode = cpu_xfer_pkg::SEQ_IDLE;
            end
            cpu_xfer_pkg::SEQ_KEY:
            begin
                if (!s.kp[cpu_xfer_pkg::SP4])
                    next_s.kp = {s.kp[cpu_xfer_pkg::NUM_SP-2:0], 1'b0};
                else
                begin
                    next_s.mode = cpu_xfer_pkg::SEQ_IDLE;
                    if (s.key_start && !rise.stop)
                        next_s.run = 1'b1;
                end
            end
            default:
                next_s.mode = cpu_xfer_pkg::SEQ_IDLE;
        endcase

        // Trap one-shot fires when the trap flag drops; a new drop beats its own consumption.
        next_s.trap_seen = i_trap_flag;
        trap_fall = s.trap_seen & ~i_trap_flag;
        trap_use = s.trap_pend & s.tp[cpu_xfer_pkg::T6] & i_cycle.prog_break_active;
        next_s.trap_pend = (s.trap_pend & ~trap_use) | trap_fall;

        next_s.inhibit = i_cycle.prog_break_active | (i_cycle.data_break & i_cycle.data_in)
                         | (i_cycle.execute & (i_op.jump_subroutine_op
                                               | i_op.deposit_zero_op));

        pc_inc = (s.tp[cpu_xfer_pkg::T1] & i_cycle.fetch)
                 | (s.tp[cpu_xfer_pkg::T5] & i_cycle.execute & i_op.skip_if_differ_op
                    & (s.accumulator_reg != '0))
                 | (s.tp[cpu_xfer_pkg::T5] & ((i_cycle.execute & i_op.jump_subroutine_op)
                    | i_cycle.prog_break_active))
                 | (s.tp[cpu_xfer_pkg::T3] & i_cycle.execute & i_op.increment_skip_zero_op
                    & (&s.memory_buffer_reg))
                 | (s.tp[cpu_xfer_pkg::T5] & i_op.operate_op
                    & op_skip(s.memory_buffer_reg, s.accumulator_reg, i_link))
                 | trap_use
                 | i_io_skip
                 | (s.kp[cpu_xfer_pkg::SP2] & s.key_sync2.tape_read_flag)
                 | (s.kp[cpu_xfer_pkg::SP4] & s.key_ex_dep);
        if (pc_inc)
            next_s.program_counter = s.program_counter + ADDR_W'(1);

        if (s.kp[cpu_xfer_pkg::SP1])
            next_s.memory_address_reg = '0;
        else if (s.tp[cpu_xfer_pkg::T7] && s.run)
            next_s.memory_address_reg = '0;
        else if (s.tp[cpu_xfer_pkg::T1] && i_cycle.fetch)
            next_s.memory_address_reg = s.program_counter;
        else if (s.tp[cpu_xfer_pkg::T1] && (i_cycle.defer || i_cycle.execute))
        begin
            if (i_op.call_op)
                next_s.memory_address_reg = cpu_xfer_pkg::CALL_VECTOR;
            else
                next_s.memory_address_reg = s.memory_buffer_reg[ADDR_W-1:0];
        end

        auto_index = i_cycle.defer & s.memory_address_reg[cpu_xfer_pkg::AUTO_ONE]
                     & (s.memory_address_reg[cpu_xfer_pkg::AUTO_ZERO_HI:
                                             cpu_xfer_pkg::AUTO_ZERO_LO] == '0);
        if (s.kp[cpu_xfer_pkg::KBGN])
            next_s.memory_buffer_reg = '0;
        else if (s.tp[cpu_xfer_pkg::T2])
            // Clearing and strobing share this edge, so the sensed ones land on a clean buffer.
            next_s.memory_buffer_reg = s.inhibit ? '0 : i_sense;
        else if (s.tp[cpu_xfer_pkg::T3] && i_cycle.execute && i_op.deposit_acc_op)
            next_s.memory_buffer_reg = s.accumulator_reg;
        else if (s.tp[cpu_xfer_pkg::T3] && (i_cycle.prog_break_active
                 || (i_cycle.execute && i_op.jump_subroutine_op)))
            next_s.memory_buffer_reg = WORD_W'(s.program_counter);
        else if (s.tp[cpu_xfer_pkg::T3] && (auto_index || i_cycle.clock_break
                 || (i_cycle.execute && i_op.increment_skip_zero_op)))
            next_s.memory_buffer_reg = s.memory_buffer_reg + WORD_W'(1);
        else if (s.tp[cpu_xfer_pkg::T7] && i_cycle.execute && s.readin)
            next_s.memory_buffer_reg = '0;
        else if (s.kp[cpu_xfer_pkg::SP3] && s.key_ex_dep)
            next_s.memory_buffer_reg = WORD_W'(s.program_counter);
        else if (s.kp[cpu_xfer_pkg::SP4] && s.key_sync2.tape_read_flag)
            next_s.memory_buffer_reg = WORD_W'(s.program_counter);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
            s <= '0;
        else
            s <= next_s;
    end

    assign o_wb = s.rsp;
    assign o_timing = s.tp;
    assign o_key_pulse = s.kp;
    assign o_memory_address = s.memory_address_reg;
    assign o_memory_buffer = s.memory_buffer_reg;
    assign o_strobe_inhibit = s.inhibit;
    assign o_run = s.run;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    sequence t_rest_s;
        s.tp[cpu_xfer_pkg::T2] ##1 s.tp[cpu_xfer_pkg::T3] ##1 s.tp[cpu_xfer_pkg::T4]
        ##1 s.tp[cpu_xfer_pkg::T5] ##1 s.tp[cpu_xfer_pkg::T6] ##1 s.tp[cpu_xfer_pkg::T7];
    endsequence
    sequence sp_rest_s;
        s.kp[cpu_xfer_pkg::SP1] ##1 s.kp[cpu_xfer_pkg::SP2] ##1 s.kp[cpu_xfer_pkg::SP3]
        ##1 s.kp[cpu_xfer_pkg::SP4];
    endsequence

    timing_order_a: assert property (s.tp[cpu_xfer_pkg::T1] |=> t_rest_s)
        else $error("Timing pulses out of order");
    key_order_a: assert property (s.kp[cpu_xfer_pkg::KBGN] |=> sp_rest_s)
        else $error("Key pulses out of order");
    fetch_load_a: assert property (s.tp[cpu_xfer_pkg::T1] && i_cycle.fetch |=>
        s.program_counter == ADDR_W'($past(s.program_counter) + 1)
        && s.memory_address_reg == $past(s.program_counter))
        else $error("Fetch T1 did not load address and step counter");
    address_clear_a: assert property (s.tp[cpu_xfer_pkg::T7] && s.run |=>
        s.memory_address_reg == '0 && s.tp[cpu_xfer_pkg::T1])
        else $error("Address not cleared at T7 or next cycle missing");
    call_vector_a: assert property (s.tp[cpu_xfer_pkg::T1] && !i_cycle.fetch
        && i_cycle.execute && i_op.call_op |=> s.memory_address_reg == cpu_xfer_pkg::CALL_VECTOR)
        else $error("Call did not load fixed address");
    strobe_block_a: assert property (s.tp[cpu_xfer_pkg::T2] && s.inhibit
        |=> s.memory_buffer_reg == '0)
        else $error("Sense data entered buffer while inhibited");
    deposit_acc_a: assert property (s.tp[cpu_xfer_pkg::T3] && i_cycle.execute
        && i_op.deposit_acc_op |=> s.memory_buffer_reg == $past(s.accumulator_reg))
        else $error("Accumulator not deposited into buffer");
    isz_step_a: assert property (s.tp[cpu_xfer_pkg::T3] && i_cycle.execute
        && i_op.increment_skip_zero_op && !i_op.deposit_acc_op && !i_op.jump_subroutine_op
        && !i_cycle.prog_break_active |=> s.memory_buffer_reg == WORD_W'($past(s.memory_buffer_reg) + 1))
        else $error("Buffer not stepped at T3");
    differ_skip_a: assert property (s.tp[cpu_xfer_pkg::T5] && i_cycle.execute
        && i_op.skip_if_differ_op && s.accumulator_reg != '0 |=>
        s.program_counter == ADDR_W'($past(s.program_counter) + 1))
        else $error("Skip-if-differ did not step counter");
    examine_pc_a: assert property (s.kp[cpu_xfer_pkg::SP3] && s.key_ex_dep
        |=> s.memory_buffer_reg == WORD_W'($past(s.program_counter))
        ##1 s.program_counter == ADDR_W'($past(s.program_counter) + 1))
        else $error("Examine or deposit key cycle wrong");
endmodule

// ### verilog/cpu_xfer_pkg.sv
// Shared constants, field positions and carrier types for the register transfer control.
// Assumes an 18-bit word with bit 0 as the most significant bit in the hardware's own numbering.
package cpu_xfer_pkg;
    localparam int WORD_W = 18;
    localparam int ADDR_W = 13;
    localparam int NUM_T = 7;
    localparam int NUM_SP = 5;
    // Timing pulse slots, T1 through T7.
    localparam int T1 = 0;
    localparam int T2 = 1;
    localparam int T3 = 2;
    localparam int T4 = 3;
    localparam int T5 = 4;
    localparam int T6 = 5;
    localparam int T7 = 6;
    // Key cycle slots: begin pulse, then SP1 through SP4.
    localparam int KBGN = 0;
    localparam int SP1 = 1;
    localparam int SP2 = 2;
    localparam int SP3 = 3;
    localparam int SP4 = 4;
    // Word bit positions as vector indices (word bit k sits at index 17 - k).
    localparam int MB8 = 9;
    localparam int MB9 = 8;
    localparam int MB10 = 7;
    localparam int MB11 = 6;
    localparam int AC_SIGN = 17;
    localparam int AUTO_ONE = 3;
    localparam int AUTO_ZERO_HI = 12;
    localparam int AUTO_ZERO_LO = 4;
    localparam logic [12:0] CALL_VECTOR = 13'h0010;
    // Wishbone register byte addresses.
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_PC = 8'h08;
    localparam logic [7:0] ADR_MA = 8'h0C;
    localparam logic [7:0] ADR_MB = 8'h10;
    localparam logic [7:0] ADR_AC = 8'h14;
    localparam int CTRL_RUN = 0;
    localparam int ST_RUN = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_READIN = 2;
    localparam int ST_INHIBIT = 3;
    typedef enum logic [2:0] {RS_NONE, RS_CTRL, RS_STATUS, RS_PC, RS_MA, RS_MB, RS_AC} reg_sel_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_MEM, SEQ_KEY} seq_mode_t;
    typedef struct packed {
        logic fetch;
        logic defer;
        logic execute;
        logic prog_break_active;
        logic data_break;
        logic data_in;
        logic clock_break;
    } cycle_t;
    typedef struct packed {
        logic skip_if_differ_op;
        logic jump_subroutine_op;
        logic increment_skip_zero_op;
        logic deposit_acc_op;
        logic deposit_zero_op;
        logic call_op;
        logic operate_op;
    } op_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic examine;
        logic deposit;
        logic readin;
        logic tape_read_flag;
    } keys_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;
endpackage
